// file: hdl/ref_detect_cfg.svh
// Purpose: constants for the reference input activity detect control
// Assumes: 250 MHz register clock, 8-bit register index port
// Notes:   offsets, fields, reset values and counts only
`ifndef REF_DETECT_CFG_SVH
`define REF_DETECT_CFG_SVH

`define REF_DETECT_CTL_INDEX   8'h19
`define SEC_METHOD_MSB         7
`define SEC_METHOD_LSB         6
`define PRI_METHOD_MSB         5
`define PRI_METHOD_LSB         4
`define SEC_THRESH_MSB         3
`define SEC_THRESH_LSB         2
`define PRI_THRESH_MSB         1
`define PRI_THRESH_LSB         0
`define REF_DETECT_CTL_RESET   8'h55
`define DETECT_WINDOW_NS       4096
`define CLK_PERIOD_NS          4
`define DETECT_WINDOW_CYCLES   (`DETECT_WINDOW_NS / `CLK_PERIOD_NS)

`endif

// file: hdl/ref_detect_pkg.sv
// Purpose: types for the reference input activity detect control
// Assumes: nothing beyond the cfg header
// Notes:   index 0 is the primary input, index 1 the secondary
package ref_detect_pkg;

    typedef enum logic [1:0] {
        METHOD_RISE  = 2'b00,
        METHOD_BOTH  = 2'b01,
        METHOD_FALL  = 2'b10,
        METHOD_LEVEL = 2'b11
    } detect_method_e;

    typedef struct packed {
        detect_method_e secondary_detect_method;
        detect_method_e primary_detect_method;
        logic [1:0]     secondary_comparator_threshold;
        logic [1:0]     primary_comparator_threshold;
    } reference_detect_control_s;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_s;

endpackage : ref_detect_pkg

// file: hdl/ref_input_energy_detect_ctl.sv
// Purpose: detect control register and per-input activity detectors
// Assumes: reference samples and level comparator flags are synchronous to clk_i
// Notes:   a valid flag updates at the end of each detection window unless its method changes in that window's last cycle
//          a method change drops what the window has gathered so far
//          edge history follows the pin through reset, so release shows no edge
`timescale 1ns/1ns
`include "ref_detect_cfg.svh"

module ref_input_energy_detect_ctl #(
    parameter int WINDOW_CYCLES = `DETECT_WINDOW_CYCLES
) (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire ref_detect_pkg::reg_req_s      reg_req_i,
    output      logic [7:0]                    reg_rdata_o,
    input  wire logic [1:0]                    ref_sample_i,
    input  wire logic [1:0]                    ref_above_high_i,
    input  wire logic [1:0]                    ref_below_low_i,
    output      logic [1:0]                    ref_valid_o,
    output      logic [1:0]                    secondary_comparator_threshold_o,
    output      logic [1:0]                    primary_comparator_threshold_o
);
    import ref_detect_pkg::*;

    // ------------------------------------------------------------
    // window sizing
    // ------------------------------------------------------------
    localparam int CW = $clog2(WINDOW_CYCLES + 1);
    localparam logic [CW-1:0] WIN_LAST = CW'(WINDOW_CYCLES - 1);

    // ------------------------------------------------------------
    // state and nets
    // ------------------------------------------------------------
    reference_detect_control_s ctl_reg;
    logic [CW-1:0]             win_cnt_reg;
    logic                      win_end;
    logic                      ctl_hit;
    logic                      ctl_write;
    logic [1:0]                method_change;
    detect_method_e            method [2];
    reference_detect_control_s ctl_next;
    logic [7:0]                rdata_next;
    logic [CW-1:0]             win_cnt_next;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    assign ctl_hit   = (reg_req_i.addr == `REF_DETECT_CTL_INDEX);
    assign ctl_write = reg_req_i.wr && ctl_hit;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        if (ctl_write) begin
            ctl_next = reference_detect_control_s'(reg_req_i.wdata);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctl_reg <= reference_detect_control_s'(`REF_DETECT_CTL_RESET);
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = reg_rdata_o;
        if (reg_req_i.rd) begin
            rdata_next = ctl_hit ? 8'(ctl_reg) : 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // threshold outputs
    // ------------------------------------------------------------
    assign secondary_comparator_threshold_o = ctl_reg.secondary_comparator_threshold;
    assign primary_comparator_threshold_o   = ctl_reg.primary_comparator_threshold;

    // ------------------------------------------------------------
    // method fields
    // ------------------------------------------------------------
    assign method[0] = ctl_reg.primary_detect_method;
    assign method[1] = ctl_reg.secondary_detect_method;

    always_comb begin
        method_change = 2'h0;
        if (ctl_write) begin
            method_change[0] = reg_req_i.wdata[`PRI_METHOD_MSB:`PRI_METHOD_LSB]
                != ctl_reg.primary_detect_method;
            method_change[1] = reg_req_i.wdata[`SEC_METHOD_MSB:`SEC_METHOD_LSB]
                != ctl_reg.secondary_detect_method;
        end
    end

    // ------------------------------------------------------------
    // detection window
    // ------------------------------------------------------------
    assign win_end = (win_cnt_reg == WIN_LAST);

    always_comb begin
        win_cnt_next = win_cnt_reg + 1'b1;
        if (win_end) begin
            win_cnt_next = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            win_cnt_reg <= '0;
        end else begin
            win_cnt_reg <= win_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // per-input detectors
    // ------------------------------------------------------------
    generate
        for (genvar i = 0; i < 2; i++) begin : g_input
            logic prev_reg;
            logic seen_a_reg;
            logic seen_b_reg;
            logic valid_reg;
            logic hit_a;
            logic hit_b;
            logic rise;
            logic fall;
            logic seen_a_next;
            logic seen_b_next;
            logic valid_next;

            // ----------------------------------------------------
            // edge events
            // ----------------------------------------------------
            always_ff @(posedge clk_i) begin
                prev_reg <= ref_sample_i[i];
            end

            assign rise = ref_sample_i[i] && !prev_reg;
            assign fall = !ref_sample_i[i] && prev_reg;

            // ----------------------------------------------------
            // method decode
            // ----------------------------------------------------
            always_comb begin
                hit_a = 1'b0;
                hit_b = 1'b1;
                unique case (method[i])
                    METHOD_RISE: begin
                        hit_a = rise;
                    end
                    METHOD_BOTH: begin
                        hit_a = rise || fall;
                    end
                    METHOD_FALL: begin
                        hit_a = fall;
                    end
                    METHOD_LEVEL: begin
                        hit_a = ref_above_high_i[i];
                        hit_b = ref_below_low_i[i];
                    end
                endcase
            end

            // ----------------------------------------------------
            // window accumulation
            // ----------------------------------------------------
            always_comb begin
                seen_a_next = seen_a_reg || hit_a;
                seen_b_next = seen_b_reg || hit_b;
                valid_next  = valid_reg;
                if (win_end && !method_change[i]) begin
                    valid_next = seen_a_next && seen_b_next;
                end
                if (win_end || method_change[i]) begin
                    seen_a_next = 1'b0;
                    seen_b_next = 1'b0;
                end
            end

            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    seen_a_reg <= 1'b0;
                    seen_b_reg <= 1'b0;
                end else begin
                    seen_a_reg <= seen_a_next;
                    seen_b_reg <= seen_b_next;
                end
            end

            // ----------------------------------------------------
            // valid flag
            // ----------------------------------------------------
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    valid_reg <= 1'b0;
                end else begin
                    valid_reg <= valid_next;
                end
            end

            // ----------------------------------------------------
            // flag out
            // ----------------------------------------------------
            assign ref_valid_o[i] = valid_reg;
        end
    endgenerate

endmodule : ref_input_energy_detect_ctl

// file: test/ref_detect_props.sv
// Purpose: port assertions for the detect control block
// Assumes: WINDOW_CYCLES equals the instance value
// Notes:   cnt mirrors the free running window
`timescale 1ns/1ns
module ref_detect_props #(parameter int WINDOW_CYCLES = 16) (
    input wire logic                     clk_i,
    input wire logic                     sys_rst_i,
    input wire ref_detect_pkg::reg_req_s reg_req_i,
    input wire logic [7:0]               reg_rdata_o,
    input wire logic [1:0]               ref_sample_i,
    input wire logic [1:0]               ref_above_high_i,
    input wire logic [1:0]               ref_below_low_i,
    input wire logic [1:0]               ref_valid_o,
    input wire logic [1:0]               secondary_comparator_threshold_o,
    input wire logic [1:0]               primary_comparator_threshold_o
);
    import ref_detect_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire logic       wr = reg_req_i.wr;
    wire logic       rd = reg_req_i.rd;
    wire logic       hit = reg_req_i.addr == 8'h19;
    wire logic [7:0] wd = reg_req_i.wdata;
    wire logic [3:0] t = {secondary_comparator_threshold_o, primary_comparator_threshold_o};
    logic [15:0]     cnt;
    always_ff @(posedge clk_i) begin
        cnt <= (sys_rst_i || cnt == 16'(WINDOW_CYCLES - 1)) ? 16'h0 : cnt + 16'h1;
    end
    property p_sec; wr && hit |=> t[3:2] == $past(wd[3:2]); endproperty
    a_sec: assert property (p_sec) else $error("sec threshold");
    property p_pri; wr && hit |=> t[1:0] == $past(wd[1:0]); endproperty
    a_pri: assert property (p_pri) else $error("pri threshold");
    property p_rdt; rd && hit |=> reg_rdata_o[3:0] == $past(t); endproperty
    a_rdt: assert property (p_rdt) else $error("read data");
    property p_unm; rd && !hit |=> reg_rdata_o == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_hold; !rd |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $fell(sys_rst_i) |-> t == 4'h5 && ref_valid_o == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset values");
    property p_win; $changed(ref_valid_o) |-> cnt == 16'h0; endproperty
    a_win: assert property (p_win) else $error("valid off window");
    property p_ign; wr && !hit |=> $stable(t); endproperty
    a_ign: assert property (p_ign) else $error("stray write");
endmodule : ref_detect_props
bind ref_input_energy_detect_ctl ref_detect_props #(
    .WINDOW_CYCLES(WINDOW_CYCLES)
) i_props (
    .clk_i                            (clk_i),
    .sys_rst_i                        (sys_rst_i),
    .reg_req_i                        (reg_req_i),
    .reg_rdata_o                      (reg_rdata_o),
    .ref_sample_i                     (ref_sample_i),
    .ref_above_high_i                 (ref_above_high_i),
    .ref_below_low_i                  (ref_below_low_i),
    .ref_valid_o                      (ref_valid_o),
    .secondary_comparator_threshold_o (secondary_comparator_threshold_o),
    .primary_comparator_threshold_o   (primary_comparator_threshold_o)
);

// file: test/testbench.sv
// Purpose: directed bench for the detect control block
// Assumes: window shortened to 16 cycles
// Notes:   a quiet phase precedes every detection step
`timescale 1ns/1ns
module testbench;
    import ref_detect_pkg::*;
    localparam int W = 16;
    logic       clk_i = 1'b0;
    logic       rst = 1'b1;
    reg_req_s   req = '0;
    logic [7:0] q;
    logic [1:0] s = 2'h0, h = 2'h0, l = 2'h0, v, st, pt;
    int         bad_count = 0, num_checks = 0;
    ref_input_energy_detect_ctl #(.WINDOW_CYCLES(W)) i_dut (.clk_i(clk_i), .sys_rst_i(rst),
        .reg_req_i(req), .reg_rdata_o(q), .ref_sample_i(s), .ref_above_high_i(h),
        .ref_below_low_i(l), .ref_valid_o(v), .secondary_comparator_threshold_o(st),
        .primary_comparator_threshold_o(pt));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) req <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_i) req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i) req <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk_i) req <= '0;
        #1 chk(q, e);
    endtask : rd
    task automatic regs;
        rd(8'h19, 8'h55);
        chk({4'h0, st, pt}, 8'h05);
        for (int c = 0; c < 4; c++) begin
            wr(8'h19, 8'(c * 8'h55));
            rd(8'h19, 8'(c * 8'h55));
            chk({4'h0, st, pt}, 8'(c * 4'h5));
        end
        wr(8'h18, 8'h00);
        rd(8'h19, 8'hFF);
        rd(8'h1A, 8'h00);
    endtask : regs
    task automatic step(input logic [7:0] c, input logic [1:0] s0, s1, h1, l1, e);
        logic [1:0] seen;
        seen = 2'h0;
        wr(8'h19, c);
        s <= s0;
        h <= 2'h0;
        l <= 2'h0;
        repeat (3 * W) @(posedge clk_i);
        s <= s1;
        h <= h1;
        l <= l1;
        repeat (2 * W + 2) begin
            @(posedge clk_i);
            #1 seen = seen | v;
        end
        chk({6'h0, seen}, {6'h0, e});
    endtask : step
    task automatic retarget;
        int n;
        n = 0;
        wr(8'h19, 8'h55);
        s <= 2'h3;
        while (v !== 2'h3 && n < 2 * W) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk({6'h0, v}, 8'h03);
        @(posedge clk_i) s <= 2'h0;
        wr(8'h19, 8'h05);
        #1 chk({6'h0, v}, 8'h03);
        repeat (W - 2) @(posedge clk_i);
        #1 chk({6'h0, v}, 8'h00);
    endtask : retarget
    task automatic detect;
        step(8'h05, 2'h0, 2'h3, 2'h0, 2'h0, 2'h3);
        step(8'h05, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
        step(8'hA5, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3);
        step(8'h55, 2'h0, 2'h3, 2'h0, 2'h0, 2'h3);
        step(8'h55, 2'h3, 2'h0, 2'h0, 2'h0, 2'h3);
        step(8'h85, 2'h3, 2'h0, 2'h0, 2'h0, 2'h2);
        step(8'hF5, 2'h0, 2'h0, 2'h3, 2'h3, 2'h3);
        step(8'hF5, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0);
        step(8'h05, 2'h0, 2'h0, 2'h3, 2'h3, 2'h0);
    endtask : detect
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (20) @(posedge clk_i);
        rst <= 1'b0;
        regs();
        detect();
        retarget();
        summarize();
    end
endmodule : testbench
